/* hw/pos_pkg.sv */
// Register map, field layout and timing constants of the pattern output sequencer
package pos_pkg;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DIVIDE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_SAMPLE = 8'h0C;
   localparam logic [7:0] REG_CSEQ = 8'h10;
   localparam logic [7:0] REG_TRIG = 8'h14;
   localparam logic [7:0] REG_RUNLEN = 8'h18;
   localparam logic [7:0] REG_COUNT = 8'h1C;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_EXTCLK = 1;
   localparam int CTRL_CLOCK_OUTPUT_PIN_EN = 2;
   localparam int CTRL_CLOCK_OUTPUT_PIN_INV = 3;
   localparam int CTRL_REPLAY = 4;
   localparam int CTRL_TRIG_EN = 5;
   localparam int CTRL_WIDE = 6;
   localparam int CTRL_SEQ_EN = 7;
   localparam int CTRL_CLEAR = 8;
   localparam int STAT_RUNNING = 0;
   localparam int STAT_EMPTY = 1;
   localparam int STAT_FULL = 2;
   localparam int STAT_UNDERRUN = 3;
   localparam int STAT_DONE = 4;
   localparam int STAT_ARMED = 5;
   localparam logic [15:0] DIVIDE_RESET = 16'h0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SAMPLE_CAP_NARROW = 32'h05F5_E100;
   localparam logic [31:0] SAMPLE_CAP_WIDE = 32'h02FA_F080;
   typedef enum logic [1:0] {POS_IDLE, POS_ARMED, POS_RUN} pos_state_t;
endpackage

/* hw/pattern_output_sequencer.sv */
// Pattern output sequencer: APB registers, sample buffer, divider, control sequences
// Notes on behaviour
// RQ1 - Pins form a data output group and a control group of inputs or outputs.
// RQ2 - Control outputs replay a user sequence autonomously with exact timing.
// RQ3 - Control inputs matching a user pattern start a run autonomously.
// RQ4 - Control input values are never stored for host readback.
// RQ5 - Host writes data samples; buffered sets can replay repeatedly.
// RQ6 - With external clock selected the clock input pin is the reference.
// RQ7 - Without external clock the internal reference clock is used.
// RQ8 - When enabled, an output clock is driven on the clock output pin.
// RQ9 - Reference divided by sixteen-bit divide value plus one.
// RQ10 - Connector runs at most 100 MHz, one 16-bit sample per tick.
// RQ11 - Local buffer keeps full-rate output while data remains.
// RQ12 - Host refills buffer during a run; run capped at 100 MByte.
// RQ13 - Run cap 100 MSample for narrow, 50 MSample for wide data.
// RQ14 - I2C clock and data pins are left unused.
// RQ15 - Outputs launch on reference rising edge regardless of clock inversion.
// RQ16 - One stored sample advances per divided reference cycle while running.
//
// The APB slave port and the placing of the registers were left to the implementer.
module pos_pattern_output_sequencer
   import pos_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int CTRL_W = 6,
   parameter int DEPTH = 1024
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic referenceClockInputPin,
   output logic clockOutputPin,
   output logic [DATA_W-1:0] dataOut,
   input wire logic [CTRL_W-1:0] ctrlIn,
   output logic [CTRL_W-1:0] ctrlOut,
   output logic [CTRL_W-1:0] ctrlOutEn,
   input wire logic i2cSclIn,
   output logic i2cSclOut,
   output logic i2cSclEn,
   input wire logic i2cSdaIn,
   output logic i2cSdaOut,
   output logic i2cSdaEn
);
   localparam int AW = $clog2(DEPTH);
   localparam int SEQ_LEN = 8;

   initial begin
      if (DATA_W != 16 || CTRL_W < 1 || CTRL_W > 8 || DEPTH < 2 || (1 << AW) != DEPTH)
         $error("pos: unsupported parameters");
   end

   logic rstMeta, rstSync;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end
   wire logic rstN = rstSync;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   // Registers
   logic [31:0] ctrl;
   logic [15:0] clockDivideValue;
   logic [SEQ_LEN*CTRL_W-1:0] seqPattern;
   logic [2*CTRL_W-1:0] trigCfg;
   logic [31:0] runLength;
   logic [31:0] sampleCount;
   logic underrun, done;
   pos_state_t state;

   wire logic wrAcc = psel && penable && pwrite;
   wire logic rdAcc = psel && penable && !pwrite;
   wire logic known = hit(paddr, REG_CTRL) || hit(paddr, REG_DIVIDE) ||
      hit(paddr, REG_STATUS) || hit(paddr, REG_SAMPLE) || hit(paddr, REG_CSEQ) ||
      hit(paddr, REG_TRIG) || hit(paddr, REG_RUNLEN) || hit(paddr, REG_COUNT);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !known;

   // Sample buffer
   logic [DATA_W-1:0] mem [DEPTH];
   logic [AW:0] wrPtr, rdPtr, fillLevel;
   wire logic bufEmpty = fillLevel == '0;
   wire logic bufFull = fillLevel[AW];
   wire logic pushReq = wrAcc && hit(paddr, REG_SAMPLE) && !bufFull;
   wire logic clearReq = wrAcc && hit(paddr, REG_CTRL) && pwdata[CTRL_CLEAR];

   // Reference clock: pin sampled through two flops
   logic extMeta, extSync, extPrev;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         extMeta <= 1'b0;
         extSync <= 1'b0;
         extPrev <= 1'b0;
      end else begin
         extMeta <= referenceClockInputPin;
         extSync <= extMeta;
         extPrev <= extSync;
      end
   end
   // Internal reference is clk itself, so every cycle is a reference edge
   wire logic refEdge = ctrl[CTRL_EXTCLK] ? (extSync && !extPrev) : 1'b1; // RQ6 RQ7

   // Divider
   logic [15:0] divCount;
   wire logic tick = refEdge && divCount == clockDivideValue; // RQ9
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) divCount <= '0;
      else if (refEdge) divCount <= tick ? 16'h0000 : divCount + 16'h0001; // RQ9
   end

   // Output clock toggles on divided ticks; internal mode tops out at clk/2
   logic targetClockSignal;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) targetClockSignal <= 1'b0;
      else if (!ctrl[CTRL_CLOCK_OUTPUT_PIN_EN]) targetClockSignal <= 1'b0;
      else if (tick) targetClockSignal <= ~targetClockSignal; // RQ8
   end
   // Inversion only flips the pin, data launch edge untouched
   assign clockOutputPin = targetClockSignal ^ ctrl[CTRL_CLOCK_OUTPUT_PIN_INV]; // RQ8 RQ15

   // Trigger watch on synchronised control inputs, never stored for readback
   logic [CTRL_W-1:0] cinMeta, cinSync;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cinMeta <= '0;
         cinSync <= '0;
      end else begin
         cinMeta <= ctrlIn;
         cinSync <= cinMeta;
      end
   end
   wire logic [CTRL_W-1:0] trigMask = trigCfg[2*CTRL_W-1:CTRL_W];
   wire logic [CTRL_W-1:0] trigVal = trigCfg[CTRL_W-1:0];
   wire logic trigHit = ((cinSync ^ trigVal) & trigMask) == '0; // RQ3 RQ4

   wire logic [31:0] sampleCap = ctrl[CTRL_WIDE] ? SAMPLE_CAP_WIDE : SAMPLE_CAP_NARROW;
   wire logic [31:0] runLimit = (runLength == '0 || runLength > sampleCap) ?
      sampleCap : runLength; // RQ12 RQ13
   wire logic running = state == POS_RUN;
   wire logic advance = running && tick && !bufEmpty; // RQ11 RQ16
   wire logic lastSample = advance && (sampleCount + 32'h1 >= runLimit);
   wire logic popReq = advance && !ctrl[CTRL_REPLAY];
   // Start request seen while idle; count must restart here, not on a later cycle
   wire logic startReq = state == POS_IDLE && wrAcc && hit(paddr, REG_CTRL) && pwdata[CTRL_RUN];
   // Replay wraps to the oldest held sample, not to slot zero
   wire logic [AW:0] replayBase = wrPtr - fillLevel;

   // Run sequencer
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) state <= POS_IDLE;
      else begin
         case (state)
            POS_IDLE: if (startReq)
               state <= pwdata[CTRL_TRIG_EN] ? POS_ARMED : POS_RUN;
            POS_ARMED: if (!ctrl[CTRL_RUN]) state <= POS_IDLE;
               else if (trigHit) state <= POS_RUN; // RQ3
            POS_RUN: if (!ctrl[CTRL_RUN] || lastSample) state <= POS_IDLE; // RQ13
            default: state <= POS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) sampleCount <= '0;
      else if (state == POS_ARMED || startReq)
         sampleCount <= '0; // RQ13
      else if (advance) sampleCount <= sampleCount + 32'h1;
   end

   // Buffer pointers; host refill may proceed during a run
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fillLevel <= '0;
      end else if (clearReq) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fillLevel <= '0;
      end else begin
         if (pushReq) wrPtr <= wrPtr + 1'b1; // RQ5 RQ12
         if (advance) rdPtr <= (ctrl[CTRL_REPLAY] && rdPtr + 1'b1 == wrPtr) ?
            replayBase : rdPtr + 1'b1; // RQ5
         if (pushReq && !popReq) fillLevel <= fillLevel + 1'b1;
         else if (popReq && !pushReq) fillLevel <= fillLevel - 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (pushReq) mem[wrPtr[AW-1:0]] <= pwdata[DATA_W-1:0];
   end

   // Data launched on the reference edge only
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) dataOut <= '0;
      else if (advance) dataOut <= mem[rdPtr[AW-1:0]]; // RQ1 RQ10 RQ15 RQ16
   end

   // Control output sequence steps once per divided tick
   logic [2:0] seqIdx;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         seqIdx <= '0;
         ctrlOut <= '0;
      end else if (!ctrl[CTRL_SEQ_EN]) begin
         seqIdx <= '0;
         ctrlOut <= '0;
      end else if (tick) begin
         seqIdx <= seqIdx + 3'd1; // RQ2
         ctrlOut <= seqPattern[seqIdx*CTRL_W +: CTRL_W]; // RQ2
      end
   end
   // Sequence enable turns the whole control group into outputs, but only while trigger enable is clear
   assign ctrlOutEn = {CTRL_W{ctrl[CTRL_SEQ_EN] && !ctrl[CTRL_TRIG_EN]}}; // RQ1

   // I2C pins stay undriven
   assign i2cSclOut = 1'b0; // RQ14
   assign i2cSclEn = 1'b0; // RQ14
   assign i2cSdaOut = 1'b0; // RQ14
   assign i2cSdaEn = 1'b0; // RQ14

   // Status flags: hardware set wins over software clear
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         underrun <= 1'b0;
         done <= 1'b0;
      end else begin
         if (running && tick && bufEmpty) underrun <= 1'b1; // RQ11
         else if (wrAcc && hit(paddr, REG_STATUS) && pwdata[STAT_UNDERRUN]) underrun <= 1'b0;
         if (lastSample) done <= 1'b1;
         else if (wrAcc && hit(paddr, REG_STATUS) && pwdata[STAT_DONE]) done <= 1'b0;
      end
   end

   // Register writes; run bit self-clears when a run ends
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl <= CTRL_RESET;
         clockDivideValue <= DIVIDE_RESET;
         seqPattern <= '0;
         trigCfg <= '0;
         runLength <= '0;
      end else begin
         if (wrAcc && hit(paddr, REG_CTRL)) ctrl <= {23'h0, pwdata[8:0] & 9'h0FF};
         else if (lastSample) ctrl[CTRL_RUN] <= 1'b0;
         if (wrAcc && hit(paddr, REG_DIVIDE)) clockDivideValue <= pwdata[15:0]; // RQ9
         if (wrAcc && hit(paddr, REG_CSEQ)) seqPattern <= pwdata[SEQ_LEN*CTRL_W-1:0]; // RQ2
         if (wrAcc && hit(paddr, REG_TRIG)) trigCfg <= pwdata[2*CTRL_W-1:0]; // RQ3
         if (wrAcc && hit(paddr, REG_RUNLEN)) runLength <= pwdata;
      end
   end

   // Read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (rdAcc) begin
         case (paddr)
            REG_CTRL: prdata = ctrl;
            REG_DIVIDE: prdata = {16'h0000, clockDivideValue};
            REG_STATUS: begin
               prdata[STAT_RUNNING] = running;
               prdata[STAT_EMPTY] = bufEmpty;
               prdata[STAT_FULL] = bufFull;
               prdata[STAT_UNDERRUN] = underrun;
               prdata[STAT_DONE] = done;
               prdata[STAT_ARMED] = state == POS_ARMED;
               prdata[31:16] = 16'(fillLevel);
            end
            REG_CSEQ: prdata = 32'(seqPattern);
            REG_TRIG: prdata = 32'(trigCfg);
            REG_RUNLEN: prdata = runLength;
            REG_COUNT: prdata = sampleCount;
            default: prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule

/* testbench/pos_sut_model.sv */
// Model of the system under test: reference clock and control inputs
module pos_sut_model (
   input wire logic clkRun,
   input wire logic [3:0] trigVal,
   output logic referenceClockInputPin,
   output logic [3:0] ctrlIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Stands still outside frames, so a stalled reference shows
   initial referenceClockInputPin = 1'b0;
   always begin
      #200;
      if (clkRun) referenceClockInputPin = ~referenceClockInputPin;
   end
   assign ctrlIn = trigVal;
endmodule

/* testbench/pos_checker_sva.sv */
// Port-level assertions of the pattern output sequencer
module pos_checker
   import pos_pkg::*;
#(parameter int CTRL_W = 6) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic referenceClockInputPin,
   input wire logic clockOutputPin,
   input wire logic [15:0] dataOut,
   input wire logic [CTRL_W-1:0] ctrlOutEn,
   input wire logic i2cSclEn,
   input wire logic i2cSdaEn
);
   // Shadow copies; self-clearing run bit is not tracked, so checks stay conservative
   logic [31:0] ctl;
   logic [15:0] div;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) ctl <= CTRL_RESET;
      else if (psel && penable && pwrite && paddr == REG_CTRL) ctl <= pwdata;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) div <= DIVIDE_RESET;
      else if (psel && penable && pwrite && paddr == REG_DIVIDE) div <= pwdata[15:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_calm;
      $stable(ctl) && $stable(div);
   endsequence
   property p_i2cIdle; !i2cSclEn && !i2cSdaEn; endproperty
   property p_seqEn;
      s_calm [*3] |-> ctrlOutEn == {CTRL_W{ctl[CTRL_SEQ_EN] & ~ctl[CTRL_TRIG_EN]}};
   endproperty
   property p_ckOff; s_calm [*3] ##0 ctl[3:2] == 2'b00 |-> !clockOutputPin; endproperty
   property p_fastTick;
      s_calm [*3] ##0 (ctl[2] && !ctl[1] && div == 16'h0000)
         |-> clockOutputPin != $past(clockOutputPin);
   endproperty
   property p_extStill;
      (ctl[1] && ctl[2] && $stable(referenceClockInputPin) && $stable(ctl)) [*8]
         |=> $stable(clockOutputPin);
   endproperty
   property p_hold; s_calm [*3] ##0 !ctl[CTRL_RUN] |-> $stable(dataOut); endproperty
   property p_ready; psel && penable |-> pready; endproperty
   property p_unmap;
      psel && penable && paddr > REG_COUNT |-> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_i2cIdle: assert property (p_i2cIdle) else $error("i2c pin driven");
   a_seqEn: assert property (p_seqEn) else $error("control enable wrong");
   a_ckOff: assert property (p_ckOff) else $error("clock out not idle");
   a_fastTick: assert property (p_fastTick) else $error("no tick each cycle");
   a_extStill: assert property (p_extStill) else $error("tick without reference");
   a_hold: assert property (p_hold) else $error("data moved while stopped");
   a_ready: assert property (p_ready) else $error("access not answered");
   a_unmap: assert property (p_unmap) else $error("unmapped access wrong");
endmodule

/* testbench/pos_pattern_output_sequencer_tb_top.sv */
// Self-checking bench of the pattern output sequencer
module pos_pattern_output_sequencer_tb_top
   import pos_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, clkRun = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
   logic pready, pslverr, clockOutputPin, referenceClockInputPin;
   logic [15:0] dataOut;
   logic [3:0] ctrlIn, ctrlOut, ctrlOutEn, trigVal = 4'h0;
   logic [15:0] q[$];
   int g[$];
   int n_fail = 0, checks = 0;
   always #25 clk = ~clk;
   pos_sut_model sut_u (.clkRun(clkRun), .trigVal(trigVal),
      .referenceClockInputPin(referenceClockInputPin), .ctrlIn(ctrlIn));
   pos_pattern_output_sequencer #(.CTRL_W(4)) dut_u (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .referenceClockInputPin(referenceClockInputPin),
      .clockOutputPin(clockOutputPin), .dataOut(dataOut), .ctrlIn(ctrlIn), .ctrlOut(ctrlOut),
      .ctrlOutEn(ctrlOutEn), .i2cSclIn(1'b1), .i2cSclOut(), .i2cSclEn(), .i2cSdaIn(1'b1),
      .i2cSdaOut(), .i2cSdaEn());
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Records each new output sample and the cycles since the previous one
   task automatic grab(input int n);
      logic [15:0] last;
      int t;
      q = {};
      g = {};
      last = dataOut;
      t = 0;
      while (q.size() < n && t < 3000) begin
         @(negedge clk);
         t++;
         if (dataOut !== last) begin
            q.push_back(dataOut);
            g.push_back(t);
            t = 0;
            last = dataOut;
         end
      end
   endtask
   task automatic final_report;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(0, REG_DIVIDE, 0);
      cmp(rv, {16'h0000, DIVIDE_RESET});
      xfer(0, 8'h20, 0);
      cmp(rv, 32'h0000_0000);
      xfer(1, REG_CSEQ, 32'h8765_4321);
      xfer(1, REG_CTRL, 32'h0000_0084);
      @(negedge clk);
      rv = {28'h0, ctrlOut};
      repeat (8) begin
         @(negedge clk);
         cmp({28'h0, ctrlOut}, rv % 8 + 1);
         rv = {28'h0, ctrlOut};
      end
      cmp({28'h0, ctrlOutEn}, 32'h0000_000F);
      for (int i = 1; i < 5; i++) xfer(1, REG_SAMPLE, 32'h1111 * i);
      xfer(1, REG_RUNLEN, 4);
      xfer(1, REG_CTRL, 32'h0000_0001);
      grab(4);
      for (int i = 0; i < 4; i++) cmp(q[i], 32'h1111 * (i + 1));
      for (int i = 1; i < 4; i++) cmp(g[i], 1);
      xfer(0, REG_STATUS, 0);
      cmp(rv & 32'h3F, 32'h12);
      xfer(1, REG_STATUS, 32'h18);
      // Replay at a quarter rate: samples stay in the buffer
      xfer(1, REG_DIVIDE, 3);
      xfer(1, REG_SAMPLE, 32'h5555);
      xfer(1, REG_SAMPLE, 32'h6666);
      xfer(1, REG_RUNLEN, 6);
      xfer(1, REG_CTRL, 32'h0000_0011);
      grab(6);
      for (int i = 0; i < 6; i++) cmp(q[i], i % 2 ? 32'h6666 : 32'h5555);
      for (int i = 1; i < 6; i++) cmp(g[i], 4);
      xfer(1, REG_STATUS, 32'h18);
      xfer(1, REG_CTRL, 32'h0000_0100);
      xfer(1, REG_SAMPLE, 32'h7777);
      xfer(1, REG_SAMPLE, 32'h8888);
      xfer(1, REG_RUNLEN, 2);
      xfer(1, REG_TRIG, 32'h0000_00FA);
      xfer(1, REG_CTRL, 32'h0000_0021);
      repeat (20) @(posedge clk);
      xfer(0, REG_STATUS, 0);
      cmp(rv & 32'h3F, 32'h20);
      trigVal <= 4'hA;
      grab(2);
      cmp(q[0], 32'h7777);
      cmp(q[1], 32'h8888);
      trigVal <= 4'h0;
      xfer(1, REG_CTRL, 32'h0000_0100);
      xfer(1, REG_STATUS, 32'h18);
      xfer(1, REG_SAMPLE, 32'h9999);
      xfer(1, REG_SAMPLE, 32'hAAAA);
      xfer(1, REG_CTRL, 32'h0000_0007);
      repeat (40) @(posedge clk);
      cmp(dataOut, 32'h8888);
      clkRun <= 1'b1;
      grab(2);
      cmp(q[0], 32'h9999);
      cmp(q[1], 32'hAAAA);
      cmp(g[1] > 30 && g[1] < 34, 1);
      @(posedge clk);
      clkRun <= 1'b0;
      xfer(1, REG_DIVIDE, 32'hFFFF_FFFF);
      xfer(0, REG_DIVIDE, 0);
      cmp(rv, 32'h0000_FFFF);
      final_report();
   end
endmodule
bind pos_pattern_output_sequencer pos_checker #(.CTRL_W(CTRL_W)) chk_u (.clk(clk),
   .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .referenceClockInputPin(referenceClockInputPin), .clockOutputPin(clockOutputPin),
   .dataOut(dataOut), .ctrlOutEn(ctrlOutEn), .i2cSclEn(i2cSclEn), .i2cSdaEn(i2cSdaEn));
